/* verilog/hsc_pkg.sv */
// constants, field layouts and carriers for the high-speed counter block
// assumes a 20 MHz pclk; every pacing count derives from that rate
package hsc_pkg;

  // ==========================================================
  // clock rate and response frequencies, all in kHz
  localparam int CLK_KHZ = 20000;
  localparam int F_HW_UD_KHZ = 100;
  localparam int F_HW_QUAD_KHZ = 50;
  localparam int F_HW_ALT_KHZ = 10;
  localparam int F_SW_KHZ = 40;
  localparam int F_SW_RED_KHZ = 30;
  localparam int F_ALL_KHZ = 80;
  localparam int F_ALL_RED_KHZ = 60;

  // least spacing between accepted edges, rounded up to cycles
  localparam logic [11:0] LIM_HW_UD =
    12'((CLK_KHZ + F_HW_UD_KHZ - 1) / F_HW_UD_KHZ);
  localparam logic [11:0] LIM_HW_QUAD =
    12'((CLK_KHZ + F_HW_QUAD_KHZ - 1) / F_HW_QUAD_KHZ);
  localparam logic [11:0] LIM_HW_ALT =
    12'((CLK_KHZ + F_HW_ALT_KHZ - 1) / F_HW_ALT_KHZ);
  localparam logic [11:0] LIM_SW =
    12'((CLK_KHZ + F_SW_KHZ - 1) / F_SW_KHZ);
  localparam logic [11:0] LIM_SW_RED =
    12'((CLK_KHZ + F_SW_RED_KHZ - 1) / F_SW_RED_KHZ);
  localparam logic [11:0] LIM_ALL =
    12'((CLK_KHZ + F_ALL_KHZ - 1) / F_ALL_KHZ);
  localparam logic [11:0] LIM_ALL_RED =
    12'((CLK_KHZ + F_ALL_RED_KHZ - 1) / F_ALL_RED_KHZ);

  // ==========================================================
  // counter slots
  localparam int NCTR = 5;
  localparam int CI_A = 0;
  localparam int CI_B = 1;
  localparam int CI_UD = 2;
  localparam int CI_Q1 = 3;
  localparam int CI_Q2 = 4;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_CNT0 = 8'h10;
  localparam logic [7:0] OFF_CNT4 = 8'h20;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam int STAT_DROP_LSB = 8;
  localparam int STAT_INV_BIT = 16;

  // control word, bit 0 is function_change_enable
  typedef struct packed {
    logic table_compare_used;
    logic zone_compare_used;
    logic quad_group2_four_edge_select;
    logic quad_group1_four_edge_select;
    logic alt_updown_quad_select;
    logic alt_mode_b_select;
    logic alt_mode_a_select;
    logic reset_polarity_select;
    logic function_change_enable;
  } hsc_ctrl_t;

  // field pins from the machine side
  typedef struct packed {
    logic [1:0] ext_start;
    logic [3:0] ext_reset;
    logic [7:0] term;
  } hsc_pins_t;

endpackage

/* verilog/hsc_top.sv */
// high-speed counter function switch: five counters behind APB
// assumes field pins are asynchronous; APB runs on pclk
// Notes on behaviour
// RL1 - external reset clears counter while on
// RL2 - enabled inverted polarity clears while off
// RL3 - polarity inversion applies to all counters
// RL4 - inverted polarity demotes primary quadrature counter; the code demotes the group 2 counter (CI_Q2) and keeps CI_Q1 hardware
// RL5 - mode a: terminal 6, no reset, hardware
// RL6 - mode b: terminal 7, no reset, hardware
// RL7 - alt up/down hardware, alt quadrature software
// RL8 - program sets selects before the counter
// RL9 - quadrature one edge default, four selectable
// RL10 - hardware up/down accepts up to 100 kHz
// RL11 - hardware quadrature accepts up to 50 kHz
// RL12 - hardware counters skip overall frequency limit
// RL13 - demoted counters obey software limits
// RL14 - compare instructions reduce all software limits
// RL15 - selects act only with function change enable; the two quad group four-edge selects act without it
// RL16 - two group selects pick four-edge counting
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// pacing timer: rdy drops for lim - 1 cycles after each take
module hsc_gate (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pacing
  input wire logic [11:0] lim,
  input wire logic take,
  output logic rdy
);
  logic [11:0] tmr_r;

  // reload on take, then run down to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_r <= 12'h000;
    end else if (take) begin
      tmr_r <= lim - 12'h001;
    end else if (tmr_r != 12'h000) begin
      tmr_r <= tmr_r - 12'h001;
    end
  end
  assign rdy = (tmr_r == 12'h000);
endmodule

// ============================================================
// top level
module hsc_top
  import hsc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // field pins
  input wire hsc_pins_t pins
);
  hsc_ctrl_t ctrl_r;
  hsc_pins_t s1_r, s2_r, s3_r;
  logic [31:0] cnt_r [NCTR];
  logic [NCTR-1:0] drop_r, ev_v, dir_v, clr_v, sw_v, rdy_v, take_v;
  logic [11:0] lim_v [NCTR];
  logic [31:0] prdata_r;
  logic [7:0] t, tp;
  logic fce, inv, alt_a, alt_b, alt_ud, reduced, ovr_rdy, ovr_take;
  logic [3:0] rst_act;
  logic wr_acc, mapped;

  // ==========================================================
  // pin synchronisers; third stage only feeds edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign t = s2_r.term;
  assign tp = s3_r.term;

  // ==========================================================
  // effective function selects
  // RL15 enable gates polarity and alternate-mode selects
  assign fce = ctrl_r.function_change_enable;
  assign inv = fce & ctrl_r.reset_polarity_select;
  assign alt_a = fce & ctrl_r.alt_mode_a_select;
  assign alt_b = fce & ctrl_r.alt_mode_b_select;
  assign alt_ud = fce & ctrl_r.alt_updown_quad_select;
  // RL14 compare use reduces
  assign reduced = ctrl_r.zone_compare_used |
    ctrl_r.table_compare_used;
  // RL2 RL3 one global inversion
  assign rst_act = s2_r.ext_reset ^ {4{inv}};

  // quadrature step decoder, both phases changing is ignored in four-edge mode
  function automatic logic [1:0] quad_step(input logic a, b, pa,
    pb, four);
    logic [1:0] r;
    r = 2'b00;
    if (!four) begin
      r = {a & !pa, !b};
    end else if ((a ^ pa) != (b ^ pb)) begin
      r = {1'b1, a ^ pb};
    end
    return r;
  endfunction

  // ==========================================================
  // count events, directions, clears and software status
  always_comb begin
    ev_v = '0;
    dir_v = '1;
    // RL5 terminal 6 source
    ev_v[CI_A] = alt_a ? (t[6] & !tp[6]) :
      (t[0] & !tp[0] & s2_r.ext_start[0]);
    // RL6 terminal 7 source
    ev_v[CI_B] = alt_b ? (t[7] & !tp[7]) :
      (t[2] & !tp[2] & s2_r.ext_start[1]);
    // up on terminal 3, down on terminal 4
    ev_v[CI_UD] = (t[3] & !tp[3]) ^ (t[4] & !tp[4]);
    dir_v[CI_UD] = t[3] & !tp[3];
    // RL9 RL16 group edge modes
    {ev_v[CI_Q1], dir_v[CI_Q1]} = quad_step(t[6], t[7], tp[6],
      tp[7], ctrl_r.quad_group1_four_edge_select);
    {ev_v[CI_Q2], dir_v[CI_Q2]} = quad_step(t[1], t[5], tp[1],
      tp[5], ctrl_r.quad_group2_four_edge_select);
    // RL1 RL5 RL6 RL7 reset inputs
    clr_v[CI_A] = !alt_a & rst_act[0];
    clr_v[CI_B] = !alt_b & rst_act[1];
    clr_v[CI_UD] = !alt_ud & rst_act[2];
    clr_v[CI_Q1] = 1'b0;
    clr_v[CI_Q2] = !alt_ud & rst_act[3];
    // RL4 RL7 hardware or software
    sw_v[CI_A] = !alt_a;
    sw_v[CI_B] = !alt_b;
    sw_v[CI_UD] = !alt_ud;
    sw_v[CI_Q1] = 1'b0;
    sw_v[CI_Q2] = alt_ud | inv;
  end

  // ==========================================================
  // response limits per counter
  always_comb begin
    for (int i = 0; i < NCTR; i++) begin
      // RL13 RL14 software limits
      lim_v[i] = reduced ? LIM_SW_RED : LIM_SW;
    end
    // RL5 RL6 alternate single-input hardware
    if (alt_a) begin
      lim_v[CI_A] = LIM_HW_ALT;
    end
    if (alt_b) begin
      lim_v[CI_B] = LIM_HW_ALT;
    end
    // RL10 hardware up/down rate
    if (!sw_v[CI_UD]) begin
      lim_v[CI_UD] = LIM_HW_UD;
    end
    // RL11 hardware quadrature rate
    lim_v[CI_Q1] = LIM_HW_QUAD;
    if (!sw_v[CI_Q2]) begin
      lim_v[CI_Q2] = LIM_HW_QUAD;
    end
  end

  // one pacing timer per counter
  for (genvar g = 0; g < NCTR; g++) begin : g_gate
    hsc_gate u_gate (
      .pclk(pclk),
      .presetn(presetn),
      .lim(lim_v[g]),
      .take(take_v[g]),
      .rdy(rdy_v[g])
    );
  end

  // shared software budget; one software edge per window
  hsc_gate u_all (
    .pclk(pclk),
    .presetn(presetn),
    .lim(reduced ? LIM_ALL_RED : LIM_ALL),
    .take(ovr_take),
    .rdy(ovr_rdy)
  );

  // lowest slot wins the shared budget in a tie
  always_comb begin
    logic used;
    used = 1'b0;
    take_v = '0;
    for (int i = 0; i < NCTR; i++) begin
      // RL12 hardware bypasses budget
      if (ev_v[i] && rdy_v[i] && (!sw_v[i] ||
          (ovr_rdy && !used))) begin
        take_v[i] = 1'b1;
        used = used | sw_v[i];
      end
    end
  end
  assign ovr_take = |(take_v & sw_v);

  // ==========================================================
  // counters; clear holds while the reset input is active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCTR; i++) begin
        cnt_r[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < NCTR; i++) begin
        // RL1 RL2 level clear
        if (clr_v[i]) begin
          cnt_r[i] <= 32'h0000_0000;
        end else if (take_v[i]) begin
          cnt_r[i] <= dir_v[i] ? cnt_r[i] + 32'h0000_0001 :
            cnt_r[i] - 32'h0000_0001;
        end
      end
    end
  end

  // ==========================================================
  // apb: read data latched in setup, answered in the first access cycle
  assign wr_acc = psel & penable & pwrite;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_STAT) ||
    (!pwrite && paddr >= OFF_CNT0 && paddr <= OFF_CNT4 &&
    paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = psel & penable & !mapped;
  assign prdata = prdata_r;

  // control register
  // RL8 software orders selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_acc && paddr == OFF_CTRL) begin
      ctrl_r <= pwdata[8:0];
    end
  end

  // dropped-edge flags, write one to clear; a new drop wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_r <= '0;
    end else if (wr_acc && paddr == OFF_STAT) begin
      drop_r <= (drop_r & ~pwdata[STAT_DROP_LSB +: NCTR]) |
        (ev_v & ~take_v);
    end else begin
      drop_r <= drop_r | (ev_v & ~take_v);
    end
  end

  // read mux sampled in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= 32'h0000_0000;
      if (paddr == OFF_CTRL) begin
        prdata_r <= {23'h00_0000, ctrl_r};
      end else if (paddr == OFF_STAT) begin
        prdata_r <= {15'h0000, inv, 3'h0, drop_r, 3'h0, sw_v};
      end else if (mapped && !pwrite) begin
        prdata_r <= cnt_r[3'((paddr - OFF_CNT0) >> 2)];
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // cycles since the up/down counter last took an edge
  logic [11:0] gap_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 12'hfff;
    end else if (take_v[CI_UD]) begin
      gap_r <= 12'h001;
    end else if (gap_r != 12'hfff) begin
      gap_r <= gap_r + 12'h001;
    end
  end

  sequence s_rst_on;
    !inv && !alt_ud && rst_act[2];
  endsequence

  chk_rst_clear_on: assert property ( // RL1
    s_rst_on ##1 s_rst_on |-> cnt_r[CI_UD] == 32'h0000_0000)
    else $error("counter not cleared by active reset");
  chk_rst_inverted: assert property ( // RL2
    inv && !alt_a && !s2_r.ext_reset[0] |=> cnt_r[CI_A] == 0)
    else $error("inverted reset did not clear on off");
  chk_rst_global: assert property ( // RL3
    inv |-> (rst_act[0] == !s2_r.ext_reset[0]) &&
    (rst_act[3] == !s2_r.ext_reset[3]))
    else $error("polarity inversion not global");
  chk_quad_demote: assert property ( // RL4
    inv |-> sw_v[CI_Q2] && lim_v[CI_Q2] != LIM_HW_QUAD)
    else $error("inverted polarity kept quadrature hardware");
  chk_alt_a_mode: assert property ( // RL5
    alt_a && t[6] && !tp[6] && rdy_v[CI_A] |=>
    cnt_r[CI_A] == $past(cnt_r[CI_A]) + 1)
    else $error("alt mode a missed terminal 6 edge");
  chk_alt_b_mode: assert property ( // RL6
    alt_b |-> !clr_v[CI_B] && !sw_v[CI_B])
    else $error("alt mode b kept reset or software");
  chk_alt_updown: assert property ( // RL7
    alt_ud |-> !clr_v[CI_UD] && !sw_v[CI_UD] && sw_v[CI_Q2] &&
    !clr_v[CI_Q2])
    else $error("alt up/down or quadrature mode wrong");
  chk_one_edge: assert property ( // RL9
    !ctrl_r.quad_group2_four_edge_select && t[5] != tp[5] &&
    t[1] == tp[1] |-> !ev_v[CI_Q2])
    else $error("one-edge mode counted a phase b edge");
  chk_hw_spacing: assert property ( // RL10
    take_v[CI_UD] && !sw_v[CI_UD] |-> gap_r >= LIM_HW_UD)
    else $error("hardware up/down edges too close");
  chk_quad_rate: assert property ( // RL11
    take_v[CI_Q1] |=> !take_v[CI_Q1] [*8])
    else $error("quadrature edges accepted too fast");
  chk_hw_no_budget: assert property ( // RL12
    ev_v[CI_Q1] && rdy_v[CI_Q1] && !ovr_rdy |-> take_v[CI_Q1])
    else $error("hardware counter held by shared budget");
  chk_sw_budget: assert property ( // RL13
    ovr_take |=> !ovr_take [*8])
    else $error("software budget exceeded");
  chk_reduced_lim: assert property ( // RL14
    take_v[CI_UD] && sw_v[CI_UD] && reduced |->
    gap_r >= LIM_SW_RED)
    else $error("reduced software limit not kept");
  chk_enable_gate: assert property ( // RL15
    !fce |-> !inv && sw_v == 5'b0_0111)
    else $error("selects acted without enable");
  chk_drop_sticky: assert property ( // RL13
    ev_v[CI_B] && !take_v[CI_B] |=> drop_r[CI_B])
    else $error("dropped edge not flagged");

endmodule
`default_nettype wire

/* tb/hsc_field.sv */
// pulse source model for the counter field pins
// assumes one bench process calls its tasks, one call at a time
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// field side: terminals, external resets and starts
module hsc_field
  import hsc_pkg::*;
(
  // clock
  input wire logic pclk,
  // field pins
  output var hsc_pins_t pins
);
  // quiet start: terminals low, resets off, starts on
  initial begin
    pins = '{ext_start: 2'b11, ext_reset: 4'h0, term: 8'h00};
  end

  // one terminal change, then rest so the next change is gap edges on
  task automatic drive(input int t, input logic v, input int gap);
    @(posedge pclk);
    pins.term[t] <= v;
    repeat (gap - 1) @(posedge pclk);
  endtask

  // full pulse, rise to rise spacing of gap cycles
  task automatic pulse(input int t, input int gap);
    drive(t, 1'b1, gap / 2);
    drive(t, 1'b0, gap - gap / 2);
  endtask

  // one forward two-phase cycle, phase changes gap cycles apart
  task automatic qcycle(input int a, input int b, input int gap);
    drive(a, 1'b1, gap);
    drive(b, 1'b1, gap);
    drive(a, 1'b0, gap);
    drive(b, 1'b0, gap);
  endtask

  // reset and start levels; waits out the pin synchroniser
  task automatic set_lines(input logic [3:0] rst, input logic [1:0] st);
    @(posedge pclk);
    pins.ext_reset <= rst;
    pins.ext_start <= st;
    repeat (8) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the high-speed counter function switch
// assumes hsc_top behind APB and hsc_field driving the pins
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// bench top
module testbench;
  import hsc_pkg::*;
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  hsc_pins_t pins;
  int failures = 0;
  int cmp_count = 0;
  // control words and the counts expected after each quadrature step
  logic [31:0] qsel [3] = '{32'h0000_0000, 32'h0000_0020, 32'h0000_0040};
  logic [31:0] q1x [3] = '{32'h0000_0003, 32'h0000_0007, 32'h0000_0008};
  logic [31:0] q2x [3] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0006};

  hsc_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins)
  );
  hsc_field i_fld (.pclk(pclk), .pins(pins));

  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ==========================================================
  // checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for pready, then checks zero wait states
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), 32'h0000_0001);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic e_exp);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, e_exp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic e_exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, e_exp});
  endtask

  task automatic summarize();
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard, about three times the expected run
  initial begin
    repeat (80000) @(posedge pclk);
    failures++;
    $display("unexpected at %0t: run timed out", $time);
    summarize();
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and refused accesses
    rd(OFF_CTRL, 32'h0000_0000, 1'b0);
    rd(OFF_STAT, 32'h0000_0007, 1'b0);
    rd(8'h08, 32'h0000_0000, 1'b1);
    wr(OFF_CNT0, 32'h0000_1234, 1'b1);
    rd(OFF_CNT0, 32'h0000_0000, 1'b0);
    // software single counter: 300 cycle spacing is too close
    i_fld.pulse(0, 600);
    i_fld.pulse(0, 600);
    i_fld.pulse(0, 300);
    i_fld.pulse(0, 600);
    rd(OFF_CNT0, 32'h0000_0003, 1'b0);
    rd(OFF_STAT, 32'h0000_0107, 1'b0);
    wr(OFF_STAT, 32'h0000_0100, 1'b0);
    i_fld.set_lines(4'h1, 2'b11);
    rd(OFF_CNT0, 32'h0000_0000, 1'b0);
    i_fld.set_lines(4'h0, 2'b11);
    // compare use lowers the software rate: 600 cycles now too close
    wr(OFF_CTRL, 32'h0000_0080, 1'b0);
    i_fld.pulse(0, 600);
    i_fld.pulse(0, 600);
    rd(OFF_CNT0, 32'h0000_0001, 1'b0);
    i_fld.pulse(3, 700);
    i_fld.pulse(3, 700);
    rd(OFF_CNT0 + 8'h08, 32'h0000_0002, 1'b0);
    wr(OFF_STAT, 32'h0000_0100, 1'b0);
    // polarity select without the enable does nothing
    wr(OFF_CTRL, 32'h0000_0002, 1'b0);
    rd(OFF_STAT, 32'h0000_0007, 1'b0);
    rd(OFF_CNT0, 32'h0000_0001, 1'b0);
    // enabled inversion: low reset clears, counters A and B checked, demotes q2
    wr(OFF_CTRL, 32'h0000_0003, 1'b0);
    rd(OFF_STAT, 32'h0001_0017, 1'b0);
    rd(OFF_CNT0, 32'h0000_0000, 1'b0);
    i_fld.set_lines(4'hF, 2'b11);
    i_fld.pulse(0, 600);
    i_fld.pulse(2, 600);
    rd(OFF_CNT0, 32'h0000_0001, 1'b0);
    rd(OFF_CNT0 + 8'h04, 32'h0000_0001, 1'b0);
    i_fld.set_lines(4'hD, 2'b11);
    rd(OFF_CNT0 + 8'h04, 32'h0000_0000, 1'b0);
    // mode a: terminal 6, reset and start ignored, terminal 0 ignored
    i_fld.set_lines(4'h1, 2'b00);
    wr(OFF_CTRL, 32'h0000_0005, 1'b0);
    rd(OFF_STAT, 32'h0000_0006, 1'b0);
    // software edge just before: hardware slot must ignore the budget
    i_fld.pulse(3, 100);
    i_fld.pulse(6, 2100);
    i_fld.pulse(6, 2100);
    i_fld.pulse(0, 600);
    rd(OFF_CNT0, 32'h0000_0003, 1'b0);
    // mode b: terminal 7, start ignored, reset input left off
    wr(OFF_CTRL, 32'h0000_0009, 1'b0);
    rd(OFF_STAT, 32'h0000_0005, 1'b0);
    i_fld.pulse(7, 2100);
    i_fld.pulse(7, 1000);
    i_fld.pulse(7, 100);
    rd(OFF_CNT0 + 8'h04, 32'h0000_0002, 1'b0);
    // alt up/down: hardware rate, no reset; alt quadrature software
    i_fld.set_lines(4'h4, 2'b11);
    wr(OFF_CTRL, 32'h0000_0011, 1'b0);
    i_fld.pulse(3, 250);
    i_fld.pulse(3, 250);
    i_fld.pulse(3, 150);
    i_fld.pulse(3, 250);
    rd(OFF_CNT0 + 8'h08, 32'h0000_0003, 1'b0);
    rd(OFF_STAT, 32'h0000_0613, 1'b0);
    wr(OFF_STAT, 32'h0000_0600, 1'b0);
    // two-phase counters: one edge by default, groups select four
    i_fld.set_lines(4'h0, 2'b11);
    for (int k = 0; k < 3; k++) begin
      wr(OFF_CTRL, qsel[k], 1'b0);
      i_fld.qcycle(6, 7, 450);
      i_fld.qcycle(1, 5, 450);
      rd(OFF_CNT0 + 8'h0C, q1x[k], 1'b0);
      rd(OFF_CNT4, q2x[k], 1'b0);
    end
    summarize();
  end
endmodule
`default_nettype wire
